// File: hw/dgc_dma.sv
// Four-channel DMA controller with global control, status and debug capture
//
// Summary of operation
// - Bus master moves data without processor help
// - Four channels, auto-incrementing source and destination
// - Simultaneous requests granted by fixed priority
// - Word or byte access, unaligned addresses allowed
// - Start by software or selected interrupt
// - Selected interrupt aborts ongoing channel transfer
// - One-shot, auto-repeat and channel chaining
// - Pattern match terminates the transfer
// - Done, half, empty, full, abort, address events
// - Most recent bus address captured for readback
// - One CRC generator attachable to any channel
// - Global enable bit, reset to zero
// - Suspend stops new transfers, clear resumes
// - Busy reads one while controller active
// - Status bit shows last access direction
// - Status field holds last active channel
// - Unused control and status bits read zero
`timescale 1ns/1ps
`default_nettype none
module dgc_dma
  import dgc_pkg::*;
#(
  parameter int IRQ_N = 32,
  parameter logic [31:0] ADDR_LIMIT = ADDR_LIMIT_DEF
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [IRQ_N-1:0] irq_i,
  output dgc_bus_req_type bus_o,
  input wire logic [31:0] bus_rdata_i,
  input wire logic bus_ack_i
);
  ////////////////////////////////////////////////////////////////////////
  dgc_state_type st;
  logic on, susp, last_rd;
  logic [1:0] cur, last_ch, g_ch;
  logic [31:0] last_addr, dat;
  logic wide;
  logic [31:0] cfg [DGC_NCH];
  logic [31:0] src [DGC_NCH];
  logic [31:0] dst [DGC_NCH];
  logic [31:0] pat [DGC_NCH];
  logic [15:0] size [DGC_NCH];
  logic [15:0] cnt [DGC_NCH];
  logic [FLG_W-1:0] flg [DGC_NCH];
  logic [DGC_NCH-1:0] pend, abrt, ready;
  logic crc_en;
  logic [2:0] crc_ch;
  logic [15:0] crc_poly, crc;
  logic busy, go, bad, g_wide, wr_done, ch_hit, glb_wr;
  logic [31:0] g_sa, g_da;
  logic [1:0] ch_sel;
  logic [2:0] ch_reg;
  logic [15:0] step, nxt_cnt;
  logic [7:0] cur_byte;
  logic blk_end, hit_pat;

  assign ch_hit = (addr_i[11:8] == CH_PAGE) && !addr_i[7];
  assign ch_sel = addr_i[6:5];
  assign ch_reg = addr_i[4:2];
  assign glb_wr = wr_i && (addr_i[11:8] == 4'h0);

  ////////////////////////////////////////////////////////////////////////
  // Arbitration and first-access checks
  always_comb begin
    ready = '0;
    g_ch = 2'h0;
    for (int i = 0; i < DGC_NCH; i++) begin
      ready[i] = cfg[i][C_EN] && pend[i] && !abrt[i];
    end
    for (int i = DGC_NCH - 1; i >= 0; i--) begin
      if (ready[i]) begin
        g_ch = 2'(i);
      end
    end
  end

  assign g_sa = src[g_ch] + {16'h0, cnt[g_ch]};
  assign g_da = dst[g_ch] + {16'h0, cnt[g_ch]};
  assign g_wide = (g_sa[1:0] == 2'h0) && (g_da[1:0] == 2'h0) && !cfg[g_ch][C_PAT]
    && ((size[g_ch] - cnt[g_ch]) >= 16'h4);
  assign bad = (g_sa >= ADDR_LIMIT) || (g_da >= ADDR_LIMIT);
  assign go = on && !susp && (|ready);
  assign busy = on || (st != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Transfer engine: one read then one write per transaction
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= ST_IDLE;
      bus_o <= '0;
      cur <= 2'h0;
      wide <= 1'b0;
      dat <= 32'h0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (go && !bad) begin
            cur <= g_ch;
            wide <= g_wide;
            bus_o.req <= 1'b1;
            bus_o.wr <= 1'b0;
            bus_o.addr <= g_sa;
            bus_o.be <= g_wide ? 4'hf : 4'(4'h1 << g_sa[1:0]);
            st <= ST_RD;
          end
        end
        ST_RD: begin
          if (bus_ack_i) begin
            dat <= bus_rdata_i;
            bus_o.wr <= 1'b1;
            bus_o.addr <= dst[cur] + {16'h0, cnt[cur]};
            bus_o.wdata <= wide ? bus_rdata_i
              : {4{bus_rdata_i[8*bus_o.addr[1:0] +: 8]}};
            bus_o.be <= wide ? 4'hf
              : 4'(4'h1 << (dst[cur][1:0] + cnt[cur][1:0]));
            st <= ST_WR;
          end
        end
        ST_WR: begin
          if (bus_ack_i) begin
            bus_o.req <= 1'b0;
            bus_o.wr <= 1'b0;
            st <= ST_IDLE;
          end
        end
        default: begin
          st <= ST_IDLE;
          bus_o <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Debug capture and global status
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      last_rd <= 1'b0;
      last_addr <= 32'h0;
    end else if (bus_o.req && bus_ack_i) begin
      last_addr <= bus_o.addr;
      last_rd <= !bus_o.wr;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      last_ch <= 2'h0;
    end else if (st == ST_IDLE && go && !bad) begin
      last_ch <= g_ch;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      on <= 1'b0;
      susp <= 1'b0;
    end else if (glb_wr && addr_i == OFF_CTRL) begin
      on <= wdata_i[B_ON];
      susp <= wdata_i[B_SUSP];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completion arithmetic for the channel being served
  assign wr_done = (st == ST_WR) && bus_ack_i;
  assign step = wide ? 16'h4 : 16'h1;
  assign nxt_cnt = cnt[cur] + step;
  assign cur_byte = bus_o.wdata[7:0];
  assign hit_pat = cfg[cur][C_PAT] && (cur_byte == pat[cur][7:0]);
  assign blk_end = (nxt_cnt >= size[cur]) || hit_pat;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DGC_NCH; i++) begin
        cfg[i] <= 32'h0;
        src[i] <= 32'h0;
        dst[i] <= 32'h0;
        pat[i] <= 32'h0;
        size[i] <= 16'h0;
        cnt[i] <= 16'h0;
        flg[i] <= '0;
      end
      pend <= '0;
      abrt <= '0;
    end else begin
      for (int i = 0; i < DGC_NCH; i++) begin
        logic [FLG_W-1:0] set;
        logic sel_wr, act;
        set = '0;
        sel_wr = wr_i && ch_hit && (ch_sel == 2'(i));
        act = (st != ST_IDLE) && (cur == 2'(i));
        if (sel_wr) begin
          case (ch_reg)
            CHR_CFG: cfg[i] <= wdata_i;
            CHR_SRC: src[i] <= wdata_i;
            CHR_DST: dst[i] <= wdata_i;
            CHR_PAT: pat[i] <= wdata_i;
            CHR_SIZE: begin
              size[i] <= wdata_i[15:0];
              cnt[i] <= 16'h0;
            end
            default: begin
            end
          endcase
        end
        // Start request from software or the chosen interrupt line
        if ((sel_wr && ch_reg == CHR_CMD && wdata_i[K_START])
          || (cfg[i][C_SIRQ] && irq_i[cfg[i][C_SSEL +: SEL_W]])) begin
          pend[i] <= 1'b1;
        end
        if ((sel_wr && ch_reg == CHR_CMD && wdata_i[K_ABORT])
          || (cfg[i][C_EN] && cfg[i][C_AIRQ] && irq_i[cfg[i][C_ASEL +: SEL_W]])) begin
          abrt[i] <= 1'b1;
        end
        // Abort lands only between transactions
        if (abrt[i] && !act) begin
          abrt[i] <= 1'b0;
          pend[i] <= 1'b0;
          cnt[i] <= 16'h0;
          cfg[i][C_EN] <= 1'b0;
          set[F_ABORT] = 1'b1;
        end
        if (st == ST_IDLE && go && bad && g_ch == 2'(i)) begin
          pend[i] <= 1'b0;
          cfg[i][C_EN] <= 1'b0;
          set[F_ADDR] = 1'b1;
        end
        if (wr_done && cur == 2'(i)) begin
          cnt[i] <= nxt_cnt;
          if (cnt[i] < (size[i] >> 1) && nxt_cnt >= (size[i] >> 1)) begin
            set[F_SHALF] = 1'b1;
            set[F_DHALF] = 1'b1;
          end
          if (blk_end) begin
            cnt[i] <= 16'h0;
            pend[i] <= 1'b0;
            set[F_DONE] = 1'b1;
            set[F_SEMPTY] = !hit_pat;
            set[F_DFULL] = !hit_pat;
            if (!cfg[i][C_AUTO]) begin
              cfg[i][C_EN] <= 1'b0;
            end
          end
        end
        // Chaining: previous channel's block end enables this one
        if (i > 0 && cfg[i][C_CHAIN] && wr_done && blk_end && cur == 2'(i - 1)) begin
          cfg[i][C_EN] <= 1'b1;
        end
        if (sel_wr && ch_reg == CHR_FLG) begin
          flg[i] <= (flg[i] & ~wdata_i[FLG_W-1:0]) | set;
        end else begin
          flg[i] <= flg[i] | set;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared CRC generator, MSB first over the written data
  function automatic logic [15:0] crc_step(input logic [15:0] c_in,
    input logic [31:0] d, input int n);
    logic [15:0] c;
    logic fb;
    c = c_in;
    for (int k = 0; k < 32; k++) begin
      if (k < n) begin
        fb = c[15] ^ d[n - 1 - k];
        c = {c[14:0], 1'b0} ^ (fb ? crc_poly : 16'h0);
      end
    end
    return c;
  endfunction

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      crc_en <= 1'b0;
      crc_ch <= 3'h0;
      crc_poly <= CRC_POLY_RST;
      crc <= 16'h0;
    end else begin
      if (glb_wr && addr_i == OFF_CRC_CFG) begin
        crc_en <= wdata_i[R_EN];
        crc_ch <= wdata_i[R_CH +: 3];
      end
      if (glb_wr && addr_i == OFF_CRC_POLY) begin
        crc_poly <= wdata_i[15:0];
      end
      if (glb_wr && addr_i == OFF_CRC_DATA) begin
        crc <= wdata_i[15:0];
      end else if (wr_done && crc_en && crc_ch == {1'b0, cur}) begin
        crc <= crc_step(crc, wide ? dat : {24'h0, cur_byte}, wide ? 32 : 8);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      rdata_o <= 32'h0;
      if (ch_hit) begin
        case (ch_reg)
          CHR_CFG: rdata_o <= cfg[ch_sel];
          CHR_FLG: rdata_o <= {{(32-FLG_W){1'b0}}, flg[ch_sel]};
          CHR_SRC: rdata_o <= src[ch_sel];
          CHR_DST: rdata_o <= dst[ch_sel];
          CHR_SIZE: rdata_o <= {16'h0, size[ch_sel]};
          CHR_PAT: rdata_o <= pat[ch_sel];
          CHR_CNT: rdata_o <= {16'h0, cnt[ch_sel]};
          default: rdata_o <= 32'h0;
        endcase
      end else begin
        case (addr_i)
          OFF_CTRL: begin
            rdata_o[B_ON] <= on;
            rdata_o[B_SUSP] <= susp;
            rdata_o[B_BUSY] <= busy;
          end
          OFF_STAT: begin
            rdata_o[B_LAST_ACCESS_DIRECTION] <= last_rd;
            rdata_o[2:0] <= {1'b0, last_ch};
          end
          OFF_ADDR: rdata_o <= last_addr;
          OFF_CRC_CFG: rdata_o <= {24'h0, crc_en, 4'h0, crc_ch};
          OFF_CRC_POLY: rdata_o <= {16'h0, crc_poly};
          OFF_CRC_DATA: rdata_o <= {16'h0, crc};
          default: rdata_o <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_rd_ack;
    st == ST_RD && bus_ack_i;
  endsequence
  sequence s_grant;
    st == ST_IDLE && go && !bad;
  endsequence

  a_suspend_holds: assert property (st == ST_IDLE && susp |=> st == ST_IDLE)
    else $error("transfer started while suspended");
  a_off_holds: assert property (st == ST_IDLE && !on |=> st == ST_IDLE)
    else $error("transfer started while disabled");
  a_busy_level: assert property (rd_i && addr_i == OFF_CTRL && bus_o.req
    |=> rdata_o[B_BUSY])
    else $error("busy not read as one during a transaction");
  a_read_then_write: assert property (s_rd_ack |=> st == ST_WR && bus_o.req && bus_o.wr)
    else $error("read not followed by write");
  a_dir_after_read: assert property (s_rd_ack |=> last_rd ##1 (st != ST_WR || last_rd))
    else $error("direction not read after read access");
  a_chan_recorded: assert property (s_grant |=> last_ch == $past(g_ch) && cur == last_ch)
    else $error("last channel not recorded");
  a_addr_capture: assert property (bus_o.req && bus_ack_i |=> last_addr == $past(bus_o.addr))
    else $error("bus address not captured");
  a_prio_low: assert property (s_grant and ready[0] |=> cur == 2'h0)
    else $error("lower channel lost arbitration");
  a_stat_zero: assert property (rd_i && addr_i == OFF_STAT |=> rdata_o[31:4] == 28'h0)
    else $error("status unused bits not zero");
  a_byte_lane: assert property (s_rd_ack and (!wide) |=> $onehot(bus_o.be))
    else $error("byte write enables more than one lane");
endmodule
`default_nettype wire

// File: include/dgc_pkg.sv
// Shared constants and types of the four-channel DMA controller
package dgc_pkg;
  localparam int DGC_NCH = 4;
  // Global register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h010;
  localparam logic [11:0] OFF_ADDR = 12'h020;
  localparam logic [11:0] OFF_CRC_CFG = 12'h030;
  localparam logic [11:0] OFF_CRC_POLY = 12'h034;
  localparam logic [11:0] OFF_CRC_DATA = 12'h038;
  // Channel window: base + channel * stride, word index inside
  localparam logic [3:0] CH_PAGE = 4'h1;
  localparam logic [2:0] CHR_CFG = 3'h0;
  localparam logic [2:0] CHR_CMD = 3'h1;
  localparam logic [2:0] CHR_FLG = 3'h2;
  localparam logic [2:0] CHR_SRC = 3'h3;
  localparam logic [2:0] CHR_DST = 3'h4;
  localparam logic [2:0] CHR_SIZE = 3'h5;
  localparam logic [2:0] CHR_PAT = 3'h6;
  localparam logic [2:0] CHR_CNT = 3'h7;
  // Global control and status bit positions
  localparam int B_ON = 15;
  localparam int B_SUSP = 12;
  localparam int B_BUSY = 11;
  localparam int B_LAST_ACCESS_DIRECTION = 3;
  // Channel configuration bit positions
  localparam int C_EN = 7;
  localparam int C_PAT = 6;
  localparam int C_CHAIN = 5;
  localparam int C_AUTO = 4;
  localparam int C_SIRQ = 8;
  localparam int C_AIRQ = 9;
  localparam int C_SSEL = 16;
  localparam int C_ASEL = 24;
  localparam int SEL_W = 5;
  // Command bits
  localparam int K_START = 0;
  localparam int K_ABORT = 1;
  // Channel event flag positions
  localparam int F_ADDR = 0;
  localparam int F_ABORT = 1;
  localparam int F_DONE = 2;
  localparam int F_SHALF = 3;
  localparam int F_SEMPTY = 4;
  localparam int F_DHALF = 5;
  localparam int F_DFULL = 6;
  localparam int FLG_W = 7;
  // CRC configuration bit positions
  localparam int R_EN = 7;
  localparam int R_CH = 0;
  localparam logic [15:0] CRC_POLY_RST = 16'h1021;
  localparam logic [31:0] ADDR_LIMIT_DEF = 32'h8000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD = 3'b010,
    ST_WR = 3'b100
  } dgc_state_type;

  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } dgc_bus_req_type;
endpackage

// File: testbench/dgc_mem_model.sv
// Byte-wide memory that answers the DMA bus requests
`timescale 1ns/1ps
`default_nettype none
module dgc_mem_model
  import dgc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [3:0] lat_i,
  input wire dgc_bus_req_type bus_i,
  output logic [31:0] rdata_o,
  output logic ack_o
);
  logic [7:0] mem [0:255];
  logic [3:0] wait_cnt;
  logic [7:0] base;
  assign base = {bus_i.addr[7:2], 2'b00};
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    wait_cnt = 4'h0;
    ack_o = 1'b0;
    rdata_o = 32'h0;
  end
  ////////////////////////////////////////////////////////////////
  // Ack after lat_i cycles; read data stand only in the ack cycle
  always @(posedge mclk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (ack_o || !bus_i.req) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt < lat_i) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      ack_o <= 1'b1;
      if (!bus_i.wr) begin
        rdata_o <= {mem[base+3], mem[base+2], mem[base+1], mem[base]};
      end
    end
    if (ack_o && bus_i.req && bus_i.wr) begin
      for (int b = 0; b < 4; b++) if (bus_i.be[b]) mem[base+b] <= bus_i.wdata[8*b+:8];
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_dgc_dma.sv
// Register-level testbench of the DMA channels, global control, status and CRC
`timescale 1ns/1ps
`default_nettype none
module tb_dgc_dma
  import dgc_pkg::*;
;
  logic mclk_i;
  logic sys_rst_i;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [31:0] irq;
  dgc_bus_req_type bus;
  logic [31:0] bus_rdata;
  logic bus_ack;
  logic [3:0] lat;
  logic [31:0] d;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;

  dgc_dma dgc_dma_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_i(irq),
    .bus_o(bus), .bus_rdata_i(bus_rdata), .bus_ack_i(bus_ack));
  dgc_mem_model dgc_mem_model_inst (.mclk_i(mclk_i), .lat_i(lat), .bus_i(bus),
    .rdata_o(bus_rdata), .ack_o(bus_ack));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [11:0] cha(input logic [2:0] n, input logic [2:0] k);
    return {CH_PAGE, n, k, 2'b00};
  endfunction
  function automatic logic [7:0] ini(input int a);
    return 8'(a) ^ 8'h5a;
  endfunction
  // Reference CRC, most significant data bit first
  function automatic logic [15:0] crc_ref(input logic [15:0] c_in, input logic [31:0] w);
    logic [15:0] c;
    c = c_in;
    for (int k = 31; k >= 0; k--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[k]) ? CRC_POLY_RST : 16'h0);
    end
    return c;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic ch_run(input logic [2:0] n, input logic [31:0] s, input logic [31:0] t,
      input logic [31:0] len, input logic [31:0] cfg, input logic go);
    wr_reg(cha(n, CHR_CFG), cfg);
    wr_reg(cha(n, CHR_SRC), s);
    wr_reg(cha(n, CHR_DST), t);
    wr_reg(cha(n, CHR_SIZE), len);
    if (go) wr_reg(cha(n, CHR_CMD), 32'h1 << K_START);
  endtask
  task automatic wait_done(input logic [2:0] n);
    logic [31:0] f;
    f = 32'h0;
    for (int i = 0; i < 100 && f[F_DONE] !== 1'b1; i++) rd_reg(cha(n, CHR_FLG), f);
    chk({31'h0, f[F_DONE]}, 32'h1);
    wr_reg(cha(n, CHR_FLG), 32'h7f);
  endtask
  task automatic wait_req();
    for (int i = 0; i < 100 && bus.req !== 1'b1; i++) @(posedge mclk_i) #1;
    chk({31'h0, bus.req}, 32'h1);
  endtask
  task automatic chk_mem(input int t, input int s, input int len);
    for (int i = 0; i < len; i++) chk({24'h0, dgc_mem_model_inst.mem[t+i]}, {24'h0, ini(s+i)});
  endtask
  ////////////////////////////////////////////////////////////////
  // Whole run takes about 450 cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    addr = 12'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    irq = 32'h0;
    lat = 4'h1;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd_reg(OFF_CTRL, d); chk(d, 32'h0);
    rd_reg(OFF_STAT, d); chk(d, 32'h0);
    rd_reg(12'h0fc, d); chk(d, 32'h0);
    wr_reg(OFF_CTRL, 32'hffff_ffff);
    rd_reg(OFF_CTRL, d); chk(d, 32'h0000_9800);
    $display("test reset and control done");
    wr_reg(OFF_CTRL, 32'h1 << B_ON);
    ch_run(1, 32'h10, 32'h40, 32'h8, 32'h1 << C_EN, 1'b1);
    wait_done(1);
    chk_mem(32'h40, 32'h10, 8);
    rd_reg(OFF_STAT, d); chk(d, 32'h1);
    rd_reg(OFF_ADDR, d); chk(d, 32'h44);
    lat <= 4'h3;
    ch_run(2, 32'h21, 32'h52, 32'h3, 32'h1 << C_EN, 1'b1);
    wait_done(2);
    chk_mem(32'h52, 32'h21, 3);
    chk_mem(32'h55, 32'h55, 1);
    rd_reg(OFF_STAT, d); chk(d, 32'h2);
    rd_reg(OFF_ADDR, d); chk(d, 32'h54);
    $display("test word and byte moves done");
    ch_run(3, 32'h60, 32'h70, 32'h4, (32'h1 << C_EN) | (32'h1 << C_SIRQ) | (32'h5 << C_SSEL), 1'b0);
    repeat (10) @(posedge mclk_i);
    chk({31'h0, bus.req}, 32'h0);
    irq <= 32'h20;
    @(posedge mclk_i);
    irq <= 32'h0;
    wait_done(3);
    chk_mem(32'h70, 32'h60, 4);
    wr_reg(cha(0, CHR_PAT), {24'h0, ini(32'h81)});
    ch_run(0, 32'h80, 32'ha0, 32'h4, (32'h1 << C_EN) | (32'h1 << C_PAT), 1'b1);
    wait_done(0);
    chk_mem(32'ha0, 32'h80, 1);
    chk_mem(32'ha3, 32'ha3, 1);
    ch_run(0, 32'h8000_0000, 32'h40, 32'h4, 32'h1 << C_EN, 1'b1);
    repeat (10) @(posedge mclk_i);
    rd_reg(cha(0, CHR_FLG), d); chk(d, 32'h1 << F_ADDR);
    wr_reg(cha(0, CHR_FLG), 32'h7f);
    $display("test trigger, pattern and address fault done");
    wr_reg(OFF_CTRL, (32'h1 << B_ON) | (32'h1 << B_SUSP));
    ch_run(1, 32'h80, 32'hc0, 32'h4, 32'h1 << C_EN, 1'b1);
    ch_run(0, 32'h90, 32'hd0, 32'h4, 32'h1 << C_EN, 1'b1);
    repeat (8) @(posedge mclk_i);
    chk({31'h0, bus.req}, 32'h0);
    wr_reg(OFF_CTRL, 32'h1 << B_ON);
    wait_req();
    chk(bus.addr, 32'h90);
    wait_done(0);
    wait_done(1);
    rd_reg(OFF_STAT, d); chk(d, 32'h1);
    $display("test suspend and priority done");
    lat <= 4'h8;
    ch_run(3, 32'h00, 32'he0, 32'h10, 32'h1 << C_EN, 1'b1);
    wait_req();
    wr_reg(OFF_CTRL, 32'h0);
    @(posedge mclk_i);
    rd_reg(OFF_CTRL, d); chk(d, 32'h1 << B_BUSY);
    repeat (40) @(posedge mclk_i);
    rd_reg(OFF_CTRL, d); chk(d, 32'h0);
    rd_reg(cha(3, CHR_CNT), d); chk(d, 32'h4);
    chk({31'h0, bus.req}, 32'h0);
    $display("test disable done");
    ch_run(3, 32'h38, 32'hb8, 32'h4, 32'h1 << C_CHAIN, 1'b1);
    wr_reg(OFF_CTRL, 32'h1 << B_ON);
    ch_run(1, 32'h00, 32'hf0, 32'h10, 32'h1 << C_EN, 1'b1);
    wait_req();
    wr_reg(cha(1, CHR_CMD), 32'h1 << K_ABORT);
    repeat (40) @(posedge mclk_i);
    rd_reg(cha(1, CHR_FLG), d); chk(d, 32'h1 << F_ABORT);
    rd_reg(cha(1, CHR_CNT), d); chk(d, 32'h0);
    chk_mem(32'hf0, 32'h00, 4);
    chk_mem(32'hf4, 32'hf4, 4);
    wr_reg(cha(1, CHR_FLG), 32'h7f);
    lat <= 4'h1;
    wr_reg(OFF_CRC_CFG, (32'h1 << R_EN) | 32'h2);
    ch_run(2, 32'h30, 32'hb0, 32'h4, 32'h1 << C_EN, 1'b1);
    wait_done(2);
    wait_done(3);
    chk_mem(32'hb0, 32'h30, 4);
    chk_mem(32'hb8, 32'h38, 4);
    rd_reg(OFF_CRC_DATA, d);
    chk(d, {16'h0, crc_ref(16'h0, {ini(32'h33), ini(32'h32), ini(32'h31), ini(32'h30)})});
    $display("test abort, chain and crc done");
    finish_test();
  end
endmodule
`default_nettype wire
